// ===== hw/gdb_bank.v
// What this block does
// - Each pin owns one data bit and one eight-bit configuration register.
// - Data bits are packed eight to a register, each pin at a fixed bit.
// - Reading an input pin's data bit returns the level now sampled on the pin.
// - An output pin drives the value last written to its data bit.
// - An access latches the bit: sampled input on reading an input pin, written value on writing an output pin.
// - Six data registers sit at consecutive indices 4B to 50.
// - Config bit 0 is direction, 1 input; bit 1 inverts the pin value.
// - Config bit 7 picks open drain (1) or push-pull (0) for outputs.
// - Writing the data bit of an input pin changes neither pin nor readback.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gdb_consts.vh"

module gdb_bank #(
    parameter NUM_PINS = `GDB_NUM_PINS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [47:0] pin_in,
    output wire [47:0] pin_out,
    output wire [47:0] pin_oe
);

    localparam [47:0] VALID_MASK = `GDB_VALID_MASK;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    // One data bit and one configuration byte per position, reserved ones included
    reg [47:0] data_reg;
    reg [47:0] data_next;
    reg [7:0] cfg_reg [0:47];
    wire [47:0] in_level;
    wire [47:0] cfg_dir;
    wire [47:0] cfg_inv;
    wire [47:0] cfg_od;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Byte address to word index; the two low address bits must be zero
    wire [9:0] idx;
    wire aligned;
    wire hit_data;
    wire hit_cfg;
    wire [9:0] bank_off;
    wire [2:0] bank_sel;
    wire [5:0] cfg_sel;
    wire access_prep;
    wire access_done;

    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_data = aligned && (idx >= `GDB_IDX_BANK_1) && (idx <= `GDB_IDX_BANK_6);
    assign hit_cfg = aligned && (idx >= `GDB_IDX_CFG_BASE) && (idx <= `GDB_IDX_CFG_LAST);
    // The data registers have consecutive indices, so the bank number is the
    // index less the first one; hit_data keeps every other index out of it.
    assign bank_off = idx - `GDB_IDX_BANK_1;
    assign bank_sel = bank_off[2:0];
    assign cfg_sel = idx[5:0];

    // One wait state: pready rises at the first access edge, the transfer ends at the next
    assign access_prep = psel && penable && !pready;
    assign access_done = psel && penable && pready;

    ////////////////////////////////////////////////////////////////////////////////
    // Transfer strobes

    // A read acts at the first access edge and a write at the completion edge, so
    // the byte software reads is the very level latched into the data bit.
    // Holding the write back one cycle costs nothing, as the wait state is fixed.
    wire rd_strobe;
    wire wr_strobe;
    wire map_err;
    wire cfg_valid;
    wire wr_cfg;

    assign rd_strobe = access_prep && !pwrite;
    assign wr_strobe = access_done && pwrite;
    assign map_err = !(hit_data || hit_cfg);
    // Reserved positions keep no configuration, so writes to them fall away
    assign cfg_valid = hit_cfg && VALID_MASK[cfg_sel];
    assign wr_cfg = wr_strobe && cfg_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin configuration fields

    // Config bits 2 to 6 are stored and read back but steer nothing
    genvar g;
    generate
        for (g = 0; g < 48; g = g + 1) begin : g_pin
            assign cfg_dir[g] = cfg_reg[g][`GDB_CFG_DIR_BIT];
            assign cfg_inv[g] = cfg_reg[g][`GDB_CFG_INV_BIT];
            assign cfg_od[g] = cfg_reg[g][`GDB_CFG_OD_BIT];

            // Reserved positions get a cell too; VALID keeps it from ever driving
            gdb_pin_cell #(
                .VALID(VALID_MASK[g])
            ) u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(pin_in[g]),
                .data_bit(data_reg[g]),
                .cfg_dir(cfg_dir[g]),
                .cfg_inv(cfg_inv[g]),
                .cfg_od(cfg_od[g]),
                .in_level(in_level[g]),
                .pin_out(pin_out[g]),
                .pin_oe(pin_oe[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Live view of the data bits: inputs show the pin, outputs the stored bit

    // Input bits come through the pin synchroniser, three to four clocks late;
    // a pulse caught by fewer than two consecutive clock edges is never seen by software.
    reg [47:0] live_bits;
    integer p;

    always @* begin
        live_bits = 48'h000000000000;
        for (p = 0; p < NUM_PINS; p = p + 1) begin
            if (!VALID_MASK[p]) begin
                live_bits[p] = 1'b0;
            end else if (cfg_dir[p]) begin
                live_bits[p] = in_level[p];
            end else begin
                live_bits[p] = data_reg[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data selection

    // Only the low byte of a word carries data; the upper bytes always read zero
    reg [7:0] bank_read;
    reg [7:0] rd_byte;

    always @* begin
        case (bank_sel)
            3'h0: bank_read = live_bits[7:0];
            3'h1: bank_read = live_bits[15:8];
            3'h2: bank_read = live_bits[23:16];
            3'h3: bank_read = live_bits[31:24];
            3'h4: bank_read = live_bits[39:32];
            3'h5: bank_read = live_bits[47:40];
            default: bank_read = 8'h00;
        endcase
    end

    always @* begin
        rd_byte = 8'h00;
        if (hit_data) begin
            rd_byte = bank_read;
        end else if (hit_cfg) begin
            if (VALID_MASK[cfg_sel]) begin
                rd_byte = cfg_reg[cfg_sel];
            end else begin
                // Configuration of a reserved position is not implemented
                rd_byte = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data bit next state

    // Bytes of the selected bank only; bank numbers past five match no register
    reg [47:0] bank_mask;
    reg [47:0] wr_bits;

    always @* begin
        bank_mask = 48'h000000000000;
        wr_bits = 48'h000000000000;
        case (bank_sel)
            3'h0: begin
                bank_mask[7:0] = 8'hFF;
                wr_bits[7:0] = pwdata[7:0];
            end
            3'h1: begin
                bank_mask[15:8] = 8'hFF;
                wr_bits[15:8] = pwdata[7:0];
            end
            3'h2: begin
                bank_mask[23:16] = 8'hFF;
                wr_bits[23:16] = pwdata[7:0];
            end
            3'h3: begin
                bank_mask[31:24] = 8'hFF;
                wr_bits[31:24] = pwdata[7:0];
            end
            3'h4: begin
                bank_mask[39:32] = 8'hFF;
                wr_bits[39:32] = pwdata[7:0];
            end
            3'h5: begin
                bank_mask[47:40] = 8'hFF;
                wr_bits[47:40] = pwdata[7:0];
            end
            default: begin
                bank_mask = 48'h000000000000;
                wr_bits = 48'h000000000000;
            end
        endcase
    end

    // The data bit of an input pin keeps the level latched by its last read, so
    // turning the pin into an output drives that level until software writes.
    integer q;

    always @* begin
        data_next = data_reg;
        for (q = 0; q < NUM_PINS; q = q + 1) begin
            if (hit_data && bank_mask[q] && VALID_MASK[q]) begin
                if (cfg_dir[q]) begin
                    // Read latches the sampled level; a write leaves it alone
                    if (rd_strobe) begin
                        data_next[q] = in_level[q];
                    end
                end else if (wr_strobe) begin
                    data_next[q] = wr_bits[q];
                end
            end
        end
    end

    // Writes to input pins are dropped above, so the pin and readback stay put
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= `GDB_DATA_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // All positions reset as non-inverted inputs so that no pin is driven
    // before software has chosen a direction for it.
    integer c;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (c = 0; c < 48; c = c + 1) begin
                cfg_reg[c] <= `GDB_CFG_RESET;
            end
        end else if (wr_cfg) begin
            cfg_reg[cfg_sel] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer

    // Exactly one wait state on every transfer; pready, pslverr and prdata each
    // stand for one cycle, and an error answer carries zero read data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (access_prep) begin
            pready <= 1'b1;
            pslverr <= map_err;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Read data is captured at the first access edge so the value seen by
    // software equals the value latched into the data bit in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_strobe) begin
            prdata <= {24'h000000, rd_byte};
        end else begin
            prdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ===== hw/gdb_pin_cell.v
`timescale 1ns/1ps
`default_nettype none

module gdb_pin_cell #(
    parameter VALID = 1
) (
    input wire pclk,
    input wire presetn,
    input wire pin_in,
    input wire data_bit,
    input wire cfg_dir,
    input wire cfg_inv,
    input wire cfg_od,
    output wire in_level,
    output reg pin_out,
    output reg pin_oe
);

    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg stable_reg;
    wire drive;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input: three stages, a change is accepted once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            stable_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                stable_reg <= sync3_reg;
            end
        end
    end

    assign in_level = stable_reg ^ cfg_inv;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin output
    assign drive = data_bit ^ cfg_inv;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else if (VALID == 0 || cfg_dir) begin
            // Inputs and unimplemented positions never drive
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else if (cfg_od) begin
            // Open drain only pulls low; a high level comes from the board
            pin_out <= 1'b0;
            pin_oe <= ~drive;
        end else begin
            pin_out <= drive;
            pin_oe <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== shared/gdb_consts.vh
`ifndef GDB_CONSTS_VH
`define GDB_CONSTS_VH

// Register indices; the byte address on the bus is four times the index
`define GDB_IDX_BANK_1 10'h04B
`define GDB_IDX_BANK_2 10'h04C
`define GDB_IDX_BANK_3 10'h04D
`define GDB_IDX_BANK_4 10'h04E
`define GDB_IDX_BANK_5 10'h04F
`define GDB_IDX_BANK_6 10'h050
// Per-pin configuration registers, one per pin, pin n at index base + n
`define GDB_IDX_CFG_BASE 10'h000
`define GDB_IDX_CFG_LAST 10'h02F

// Configuration field positions
`define GDB_CFG_DIR_BIT 0
`define GDB_CFG_INV_BIT 1
`define GDB_CFG_OD_BIT 7

// Reset values: pins come up as non-inverted inputs, data bits clear
`define GDB_CFG_RESET 8'h01
`define GDB_DATA_RESET 48'h000000000000

// Implemented data bit positions, bank 1 in the low byte
`define GDB_VALID_MASK 48'h03FF0FFFF7FF

`define GDB_NUM_PINS 48
`define GDB_NUM_BANKS 6

`endif

// ===== testbench/gdb_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "gdb_consts.vh"
module gdb_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [47:0] pin_out,
    input wire [47:0] pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_done = psel && penable && pready && pwrite;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence
    one_wait_a: assert property (setup_s ##1 (psel && penable) |=> pready)
        else $error("pready not after one wait");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than a cycle");
    rd_upper_a: assert property (prdata[31:8] == 24'h000000)
        else $error("read data above byte");
    rd_idle_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside answer");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_zero_a: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("read data with error answer");
    unalign_err_a: assert property (done_s ##0 (paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unaligned access accepted");
    bank_ok_a: assert property (done_s ##0 (paddr >= 12'h12C && paddr <= 12'h140
        && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("data bank access refused");
    resv_quiet_a: assert property (((pin_oe | pin_out) & ~`GDB_VALID_MASK) == 48'h0)
        else $error("reserved pin driven");
    pin_write_a: assert property ($changed({pin_out, pin_oe}) |-> $past(wr_done, 2))
        else $error("pin changed without write");
endmodule
////////////////////////////////////////////////////////////////
bind gdb_bank gdb_chk i_gdb_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .pin_out, .pin_oe);
`default_nettype wire

// ===== testbench/gdb_board.sv
`timescale 1ns/1ps
`default_nettype none
module gdb_board (
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] lvl,
    output logic [47:0] pin_in
);
    // Released pins follow the board level chosen by the bench
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gdb_consts.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [47:0] lvl;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [47:0] pin_out, pin_oe, pin_in;
    int errors, check_count, cyc;
    logic [7:0] q;
    logic e;
    gdb_bank i_gdb_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
    gdb_board i_gdb_board (.pin_out, .pin_oe, .lvl, .pin_in);
    ////////////////////////////////////////////////////////////////
    function automatic logic [11:0] bk(int b);
        return {`GDB_IDX_BANK_1, 2'b00} + 12'(4 * b);
    endfunction
    function automatic logic [11:0] cf(int n);
        return 12'(4 * n);
    endfunction
    task automatic chk(string n, logic [47:0] x, logic [47:0] g);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("[ERR] pready exp 1 got %b", pready);
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk($sformatf("rd %h", a), {40'h0, x}, {40'h0, q});
    endtask
    task automatic pause();
        repeat (2) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("pins", 48'h0, pin_oe | pin_out);
        rd(cf(0), 8'h01);
        rd(cf(41), 8'h01);
    endtask
    task automatic t_map();
        logic [47:0] m;
        m = `GDB_VALID_MASK;
        lvl <= 48'hA55AC33C9669;
        repeat (8) @(posedge pclk);
        for (int b = 0; b < 6; b++) begin
            apb(1'b1, bk(b), ~lvl[8*b+:8]);
            rd(bk(b), lvl[8*b+:8] & m[8*b+:8]);
        end
        chk("oe", 48'h0, pin_oe);
        wr_cfg_inv: apb(1'b1, cf(8), 8'h03);
        rd(bk(1), 8'h97);
    endtask
    task automatic t_out();
        for (int n = 0; n < 8; n++) apb(1'b1, cf(n), 8'h00);
        pause();
        chk("latch", 48'h69, pin_out & 48'hFF);
        apb(1'b1, bk(0), 8'h5A);
        pause();
        chk("drive", 48'h5A, pin_out & 48'hFF);
        chk("oe", 48'hFF, pin_oe & 48'hFF);
        apb(1'b1, cf(0), 8'h02);
        apb(1'b1, cf(1), 8'h80);
        apb(1'b1, cf(3), 8'h82);
        pause();
        chk("inv", 48'h1, pin_out & 48'h1);
        chk("od1", 48'h0, {pin_out[1], pin_oe[1]});
        chk("od3", 48'h1, {pin_out[3], pin_oe[3]});
        rd(bk(0), 8'h5A);
    endtask
    task automatic t_resv();
        for (int n = 40; n < 48; n++) apb(1'b1, cf(n), 8'h00);
        apb(1'b1, bk(5), 8'hFF);
        pause();
        chk("oe6", 48'h03, pin_oe >> 40);
        rd(bk(5), 8'h03);
        rd(cf(47), 8'h00);
    endtask
    task automatic t_err();
        rd(12'h200, 8'h00);
        chk("err", 48'h1, {47'h0, e});
        apb(1'b1, 12'h12D, 8'h00);
        chk("err", 48'h1, {47'h0, e});
        rd(bk(0), 8'h5A);
        chk("err", 48'h0, {47'h0, e});
    endtask
    task automatic close_out();
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // A hung handshake must still reach the verdict
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        lvl = 48'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_map();
        t_out();
        t_resv();
        t_err();
        close_out();
    end
endmodule
`default_nettype wire
